/* File: hpmrc_pkg.sv */
// Constants and types for halt, power mode and reset control
package hpmrc_pkg;
    // Halt mode select encodings
    typedef enum logic [1:0] {
        MODE_LIGHT_SLEEP = 2'h0,
        MODE_TIMER_SLEEP = 2'h1,
        MODE_STOP        = 2'h2,
        MODE_RUN         = 2'h3
    } hpmrc_mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RESET   = 3'h0,
        ST_RECOVER = 3'h1,
        ST_RUN     = 3'h2,
        ST_HALT    = 3'h3,
        ST_SLEEP   = 3'h4,
        ST_WAKE    = 3'h5,
        ST_SERVICE = 3'h6
    } hpmrc_state_t;

    // Reset timing counts in clock cycles
    localparam int unsigned RST_MIN_PLAIN   = 3;
    localparam int unsigned RST_MIN_STRETCH = 2;
    localparam int unsigned RST_STRETCH     = 16;
    localparam int unsigned RST_CNT_W       = 5;
    localparam logic [1:0]  RST_RECOVER_LAST = 2'h1;

    // Halt NOP loop and I/O cycle positions
    localparam logic [1:0]  NOP_T4_POS   = 2'h3;
    localparam logic [2:0]  IO_T1_POS    = 3'h1;
    localparam logic [2:0]  IO_WAIT_POS  = 3'h3;
    localparam logic [2:0]  IO_LAST_POS  = 3'h4;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
endpackage

/* File: hpmrc_rst_stretch.sv */
// Reset acceptance and internal reset stretching
`timescale 1ns/10ps
`default_nettype none
module hpmrc_rst_stretch (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    // Synchronised reset pin level and option
    input  wire logic pin_low_i,
    input  wire logic stretch_en_i,
    // Accepted reset
    output logic      rst_act_o
);
    import hpmrc_pkg::*;

    typedef struct packed {
        logic [RST_CNT_W-1:0] cnt;
        logic                 act;
    } hpmrc_rs_t;

    hpmrc_rs_t rs_q;
    hpmrc_rs_t rs_d;
    logic [RST_CNT_W-1:0] need;

    // Count low cycles, accept, then stretch
    always_comb begin
        rs_d = rs_q;
        need = stretch_en_i ? RST_CNT_W'(RST_MIN_STRETCH) : RST_CNT_W'(RST_MIN_PLAIN);
        if (pin_low_i || rs_q.act) begin
            if (rs_q.cnt != {RST_CNT_W{1'b1}}) begin
                rs_d.cnt = rs_q.cnt + RST_CNT_W'(1);
            end
        end else begin
            rs_d.cnt = '0;
        end
        if (pin_low_i && rs_d.cnt >= need) begin
            rs_d.act = 1'b1;
        end else if (!pin_low_i && rs_q.act) begin
            // Strictly past the count so the internal reset itself lasts the full stretch
            if (!stretch_en_i || rs_q.cnt > RST_CNT_W'(RST_STRETCH)) begin
                rs_d.act = 1'b0;
                rs_d.cnt = '0;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rs_q <= '0;
        end else begin
            rs_q <= rs_d;
        end
    end

    assign rst_act_o = rs_q.act;

    sequence s_low3;
        (pin_low_i && !stretch_en_i) [*3];
    endsequence
    property p_accept_plain;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_low3 |=> rst_act_o;
    endproperty
    a_accept_plain: assert property (p_accept_plain) else $error("reset not taken after 3 cycles");

    property p_accept_stretch;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (pin_low_i && stretch_en_i) [*2] |=> rst_act_o;
    endproperty
    a_accept_stretch: assert property (p_accept_stretch) else $error("reset not taken after 2 cycles");

    property p_stretch_len;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ($fell(rs_q.act) && $past(stretch_en_i)) |-> ($past(rs_q.cnt) >= RST_CNT_W'(RST_STRETCH));
    endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("reset stretch too short");
endmodule
`default_nettype wire

/* File: hpmrc_top.sv */
// Halt power mode, halt release, reset cycle and I/O wait control
`timescale 1ns/10ps
`default_nettype none
module hpmrc_top (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_n_i,
    // Pins from the system
    input  wire logic                    ext_reset_n_i,
    input  wire logic                    nmi_n_i,
    input  wire logic                    int_n_i,
    // Configuration and core status
    input  wire hpmrc_pkg::hpmrc_mode_t  halt_mode_select_i,
    input  wire logic                    reset_out_en_i,
    input  wire logic                    int_enable_i,
    input  wire logic                    halt_instr_i,
    // I/O cycle from core
    input  wire logic                    io_start_i,
    input  wire logic                    io_onchip_i,
    input  wire logic [7:0]              onchip_data_i,
    // Clock enables
    output logic                         cgc_run_o,
    output logic                         clk_out_en_o,
    output logic                         sys_clk_en_o,
    output logic                         ctc_clk_en_o,
    output logic                         wdt_clk_en_o,
    // Halt and interrupt status
    output logic                         halt_n_o,
    output logic                         nop_exec_o,
    output logic                         int_ack_o,
    output logic                         nmi_ack_o,
    output logic                         iff_set_o,
    output logic                         svc_start_o,
    // Reset outputs
    output logic                         core_rst_o,
    output logic                         bus_float_o,
    output logic                         pc_clear_o,
    output logic [15:0]                  fetch_addr_o,
    // I/O cycle outputs
    output logic                         io_wait_o,
    output logic                         dbus_oe_o,
    output logic [7:0]                   dbus_o
);
    import hpmrc_pkg::*;

    typedef struct packed {
        logic         rst_m, rst_s, nmi_m, nmi_s, nmi_p, int_m, int_s, nmi_pend;
        hpmrc_state_t st;
        logic [1:0]   tcnt, rcnt;
        logic [2:0]   iocnt;
        logic         clock_gen_unit, clko, sysc, counter_timer_unit, wdt;
        logic         halt_n, nop, int_ack, nmi_ack, iff_set, svc;
        logic         core_rst, bus_float, pc_clear;
        logic [15:0]  faddr;
        logic         io_wait, dbus_oe;
        logic [7:0]   dbus;
    } hpmrc_core_t;

    localparam hpmrc_core_t CORE_RESET = '{
        rst_m: 1'b1, rst_s: 1'b1, nmi_m: 1'b1, nmi_s: 1'b1, nmi_p: 1'b1,
        int_m: 1'b1, int_s: 1'b1, nmi_pend: 1'b0, st: ST_RESET,
        tcnt: 2'h0, rcnt: 2'h0, iocnt: 3'h0,
        clock_gen_unit: 1'b1, clko: 1'b1, sysc: 1'b1, counter_timer_unit: 1'b1, wdt: 1'b1,
        halt_n: 1'b1, nop: 1'b0, int_ack: 1'b0, nmi_ack: 1'b0, iff_set: 1'b0, svc: 1'b0,
        core_rst: 1'b1, bus_float: 1'b1, pc_clear: 1'b0, faddr: RESET_VECTOR,
        io_wait: 1'b0, dbus_oe: 1'b0, dbus: 8'h00};

    hpmrc_core_t core_q;
    hpmrc_core_t core_d;
    logic        rst_act;
    logic        nmi_fall;
    logic        wake_req;

    hpmrc_rst_stretch u_stretch (
        .sys_clk_i    (sys_clk_i),
        .reset_n_i    (reset_n_i),
        .pin_low_i    (!core_q.rst_s),
        .stretch_en_i (reset_out_en_i),
        .rst_act_o    (rst_act)
    );

    // Next-state logic for sequencer, clocks and I/O cycle
    always_comb begin
        core_d = core_q;
        core_d.int_ack = 1'b0;
        core_d.nmi_ack = 1'b0;
        core_d.iff_set = 1'b0;
        core_d.svc = 1'b0;
        core_d.pc_clear = 1'b0;
        core_d.io_wait = 1'b0;
        // Pin synchronisers
        core_d.rst_m = ext_reset_n_i;
        core_d.rst_s = core_q.rst_m;
        core_d.nmi_m = nmi_n_i;
        core_d.nmi_s = core_q.nmi_m;
        core_d.nmi_p = core_q.nmi_s;
        core_d.int_m = int_n_i;
        core_d.int_s = core_q.int_m;
        nmi_fall = core_q.nmi_p && !core_q.nmi_s;
        wake_req = core_q.nmi_pend || nmi_fall || !core_q.int_s;
        if (nmi_fall) begin
            core_d.nmi_pend = 1'b1;
        end
        unique case (core_q.st)
            ST_RESET: begin
                if (!rst_act) begin
                    core_d.st = ST_RECOVER;
                    core_d.rcnt = 2'h0;
                    core_d.bus_float = 1'b0;
                end
            end
            ST_RECOVER: begin
                core_d.rcnt = core_q.rcnt + 2'h1;
                if (core_q.rcnt == RST_RECOVER_LAST) begin
                    core_d.st = ST_RUN;
                    core_d.core_rst = 1'b0;
                    core_d.pc_clear = 1'b1;
                    core_d.faddr = RESET_VECTOR;
                end
            end
            ST_RUN: begin
                if (halt_instr_i) begin
                    core_d.halt_n = 1'b0;
                    core_d.nop = 1'b1;
                    core_d.tcnt = 2'h0;
                    unique case (halt_mode_select_i)
                        MODE_LIGHT_SLEEP: begin
                            core_d.st = ST_SLEEP;
                            {core_d.clock_gen_unit, core_d.clko, core_d.sysc} = 3'h4;
                            {core_d.counter_timer_unit, core_d.wdt} = 2'h0;
                        end
                        MODE_TIMER_SLEEP: begin
                            core_d.st = ST_SLEEP;
                            {core_d.clock_gen_unit, core_d.clko, core_d.sysc} = 3'h6;
                            {core_d.counter_timer_unit, core_d.wdt} = 2'h2;
                        end
                        MODE_STOP: begin
                            core_d.st = ST_SLEEP;
                            {core_d.clock_gen_unit, core_d.clko, core_d.sysc} = 3'h0;
                            {core_d.counter_timer_unit, core_d.wdt} = 2'h0;
                        end
                        MODE_RUN: begin
                            core_d.st = ST_HALT;
                        end
                    endcase
                end
            end
            ST_SLEEP: begin
                if (wake_req) begin
                    core_d.st = ST_WAKE;
                    {core_d.clock_gen_unit, core_d.clko, core_d.sysc, core_d.counter_timer_unit, core_d.wdt} = 5'h1F;
                end
            end
            ST_WAKE: begin
                core_d.st = ST_HALT;
                core_d.tcnt = 2'h0;
            end
            ST_HALT: begin
                core_d.tcnt = core_q.tcnt + 2'h1;
                if (core_q.tcnt == NOP_T4_POS) begin
                    if (core_q.nmi_pend) begin
                        core_d.nmi_ack = 1'b1;
                        core_d.nmi_pend = nmi_fall;
                        core_d.st = ST_SERVICE;
                        core_d.halt_n = 1'b1;
                        core_d.nop = 1'b0;
                    end else if (!core_q.int_s && int_enable_i) begin
                        core_d.int_ack = 1'b1;
                        core_d.iff_set = 1'b1;
                        core_d.st = ST_SERVICE;
                        core_d.halt_n = 1'b1;
                        core_d.nop = 1'b0;
                    end else if (halt_mode_select_i != MODE_RUN && !wake_req) begin
                        core_d.st = ST_RUN;
                        core_d.halt_n = 1'b1;
                        core_d.nop = 1'b0;
                    end
                end
            end
            ST_SERVICE: begin
                core_d.svc = 1'b1;
                core_d.st = ST_RUN;
            end
            default: begin
                core_d.st = ST_RESET;
            end
        endcase
        // Halt left after an unaccepted wake returns to RUN with the NOP loop cleared
        if (core_q.st == ST_RUN && core_d.st == ST_RUN && core_q.nop) begin
            core_d.nop = 1'b0;
        end
        // I/O cycle: T1, T2, automatic wait, T3
        if (core_q.iocnt != 3'h0) begin
            core_d.iocnt = (core_q.iocnt == IO_LAST_POS) ? 3'h0 : core_q.iocnt + 3'h1;
        end else if (io_start_i) begin
            core_d.iocnt = IO_T1_POS;
            core_d.dbus_oe = io_onchip_i;
        end
        core_d.io_wait = (core_d.iocnt == IO_WAIT_POS);
        if (core_d.iocnt == 3'h0) begin
            core_d.dbus_oe = 1'b0;
        end
        if (core_d.dbus_oe) begin
            core_d.dbus = onchip_data_i;
        end
        // Accepted reset overrides state, clocks, halt, core reset, bus float, NMI latch and I/O cycle
        if (rst_act) begin
            core_d.st = ST_RESET;
            {core_d.clock_gen_unit, core_d.clko, core_d.sysc, core_d.counter_timer_unit, core_d.wdt} = 5'h1F;
            core_d.halt_n = 1'b1;
            core_d.nop = 1'b0;
            core_d.core_rst = 1'b1;
            core_d.bus_float = 1'b1;
            core_d.nmi_pend = 1'b0;
            core_d.iocnt = 3'h0;
            core_d.io_wait = 1'b0;
            core_d.dbus_oe = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            core_q <= CORE_RESET;
        end else begin
            core_q <= core_d;
        end
    end

    // Outputs straight from the state register
    assign cgc_run_o    = core_q.clock_gen_unit;
    assign clk_out_en_o = core_q.clko;
    assign sys_clk_en_o = core_q.sysc;
    assign ctc_clk_en_o = core_q.counter_timer_unit;
    assign wdt_clk_en_o = core_q.wdt;
    assign halt_n_o     = core_q.halt_n;
    assign nop_exec_o   = core_q.nop;
    assign int_ack_o    = core_q.int_ack;
    assign nmi_ack_o    = core_q.nmi_ack;
    assign iff_set_o    = core_q.iff_set;
    assign svc_start_o  = core_q.svc;
    assign core_rst_o   = core_q.core_rst;
    assign bus_float_o  = core_q.bus_float;
    assign pc_clear_o   = core_q.pc_clear;
    assign fetch_addr_o = core_q.faddr;
    assign io_wait_o    = core_q.io_wait;
    assign dbus_oe_o    = core_q.dbus_oe;
    assign dbus_o       = core_q.dbus;

    sequence s_halt_in(hpmrc_mode_t m);
        core_q.st == ST_RUN && halt_instr_i && !rst_act && halt_mode_select_i == m;
    endsequence
    property p_stop;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_halt_in(MODE_STOP) |=> !cgc_run_o && !clk_out_en_o && !wdt_clk_en_o && !ctc_clk_en_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mode left clocks running");
    property p_light;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_halt_in(MODE_LIGHT_SLEEP) |=> cgc_run_o && !clk_out_en_o && !sys_clk_en_o;
    endproperty
    a_light: assert property (p_light) else $error("light sleep clocks wrong");
    property p_timer;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_halt_in(MODE_TIMER_SLEEP) |=> clk_out_en_o && ctc_clk_en_o && !sys_clk_en_o;
    endproperty
    a_timer: assert property (p_timer) else $error("timer sleep clocks wrong");
    property p_run_halt;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_halt_in(MODE_RUN) |=> sys_clk_en_o && clk_out_en_o && nop_exec_o && !halt_n_o;
    endproperty
    a_run_halt: assert property (p_run_halt) else $error("run halt state wrong");
    property p_wake;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (core_q.st == ST_SLEEP && !core_q.int_s) |=> sys_clk_en_o && cgc_run_o;
    endproperty
    a_wake: assert property (p_wake) else $error("clock not restarted");
    property p_t4;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (int_ack_o || nmi_ack_o) |-> $past(core_q.tcnt) == NOP_T4_POS && $past(core_q.st) == ST_HALT;
    endproperty
    a_t4: assert property (p_t4) else $error("interrupt taken off T4");
    property p_service;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (int_ack_o && !rst_act) |-> iff_set_o && halt_n_o ##1 svc_start_o;
    endproperty
    a_service: assert property (p_service) else $error("service not started next cycle");
    property p_io_wait;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (io_start_i && core_q.iocnt == 3'h0 && !rst_act) [*1] ##1 !rst_act [*4]
            |-> !$past(io_wait_o, 2) && $past(io_wait_o, 1) && !io_wait_o;
    endproperty
    a_io_wait: assert property (p_io_wait) else $error("I/O wait not single");
    property p_onchip;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (io_start_i && io_onchip_i && core_q.iocnt == 3'h0 && !rst_act) ##1 !rst_act [*4]
            |-> $past(dbus_oe_o, 3);
    endproperty
    a_onchip: assert property (p_onchip) else $error("on-chip data not driven");
    property p_float;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        rst_act |=> bus_float_o && core_rst_o && halt_n_o;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated in reset");
    sequence s_recover;
        core_rst_o && !bus_float_o ##1 core_rst_o ##1 pc_clear_o && !core_rst_o;
    endsequence
    property p_recover;
        @(posedge sys_clk_i) disable iff (!reset_n_i || rst_act)
        $fell(bus_float_o) |-> s_recover ##0 fetch_addr_o == RESET_VECTOR;
    endproperty
    a_recover: assert property (p_recover) else $error("reset recovery wrong");
endmodule
`default_nettype wire

/* File: hpmrc_sys_model.sv */
// Behavioural model of the system logic driving reset and interrupt pins
`timescale 1ns/10ps
`default_nettype none
module hpmrc_sys_model (
    // Clock
    input  wire logic sys_clk_i,
    // Pins toward the block
    output logic      ext_reset_n_o,
    output logic      nmi_n_o,
    output logic      int_n_o
);
    // Idle pin levels from time zero
    initial begin
        ext_reset_n_o = 1'b1;
        nmi_n_o       = 1'b1;
        int_n_o       = 1'b1;
    end

    // Reset pin low for a whole number of cycles
    task automatic pulse_reset(input int cycles);
        @(posedge sys_clk_i);
        #1 ext_reset_n_o = 1'b0;
        repeat (cycles) @(posedge sys_clk_i);
        #1 ext_reset_n_o = 1'b1;
    endtask

    // Non-maskable request level, driven just after a clock edge
    task automatic set_nmi(input logic level);
        @(posedge sys_clk_i);
        #1 nmi_n_o = level;
    endtask

    // Maskable request level
    task automatic set_int(input logic level);
        @(posedge sys_clk_i);
        #1 int_n_o = level;
    endtask
endmodule
`default_nettype wire

/* File: tb_halt_power_mode_and_reset_control.sv */
// Self-checking bench for halt, power mode and reset control
`timescale 1ns/10ps
`default_nettype none
module tb_halt_power_mode_and_reset_control;
    import hpmrc_pkg::*;
    // Clock, reset and stimulus
    logic        sys_clk_i, reset_n_i, ext_reset_n, nmi_n, int_n;
    hpmrc_mode_t mode;
    logic        reset_out_en, int_enable, halt_instr, io_start, io_onchip;
    logic [7:0]  onchip_data;
    // Block outputs
    logic        cgc_run, clk_out_en, sys_clk_en, ctc_clk_en, wdt_clk_en;
    logic        halt_n, nop_exec, int_ack, nmi_ack, iff_set, svc_start;
    logic        core_rst, bus_float, pc_clear, io_wait, dbus_oe;
    logic [15:0] fetch_addr;
    logic [7:0]  dbus;
    int          miscompares, num_checks, cycles;

    hpmrc_sys_model model (.sys_clk_i(sys_clk_i), .ext_reset_n_o(ext_reset_n),
        .nmi_n_o(nmi_n), .int_n_o(int_n));

    hpmrc_top dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n),
        .nmi_n_i(nmi_n), .int_n_i(int_n), .halt_mode_select_i(mode),
        .reset_out_en_i(reset_out_en), .int_enable_i(int_enable), .halt_instr_i(halt_instr),
        .io_start_i(io_start), .io_onchip_i(io_onchip), .onchip_data_i(onchip_data),
        .cgc_run_o(cgc_run), .clk_out_en_o(clk_out_en), .sys_clk_en_o(sys_clk_en),
        .ctc_clk_en_o(ctc_clk_en), .wdt_clk_en_o(wdt_clk_en), .halt_n_o(halt_n),
        .nop_exec_o(nop_exec), .int_ack_o(int_ack), .nmi_ack_o(nmi_ack),
        .iff_set_o(iff_set), .svc_start_o(svc_start), .core_rst_o(core_rst),
        .bus_float_o(bus_float), .pc_clear_o(pc_clear), .fetch_addr_o(fetch_addr),
        .io_wait_o(io_wait), .dbus_oe_o(dbus_oe), .dbus_o(dbus));

    // Clock generation
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Advance n edges, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Value comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset exit sequence
    task automatic t_reset_exit;
        int n;
        chk({bus_float, core_rst, halt_n, dbus_oe}, 4'hE);
        tick(1);
        chk(bus_float, 1'b0);
        n = 0;
        while (core_rst === 1'b1 && n < 10) begin
            n++;
            tick(1);
        end
        chk(16'(n), 16'h0002);
        chk(pc_clear, 1'b1);
        chk(fetch_addr, 16'h0000);
        tick(2);
        $display("t_reset_exit done");
    endtask

    // Halt in one mode, then release by interrupt
    task automatic t_halt(input hpmrc_mode_t m, input logic [4:0] en, input logic use_nmi);
        int i;
        mode = m;
        halt_instr = 1'b1;
        tick(1);
        halt_instr = 1'b0;
        chk({halt_n, nop_exec}, 2'h1);
        chk({cgc_run, clk_out_en, sys_clk_en, ctc_clk_en, wdt_clk_en}, en);
        if (use_nmi)
            model.set_nmi(1'b0);
        else
            model.set_int(1'b0);
        for (i = 0; i < 30 && (int_ack | nmi_ack) !== 1'b1; i++)
            tick(1);
        chk({int_ack, nmi_ack}, use_nmi ? 2'h1 : 2'h2);
        chk({iff_set, halt_n}, {!use_nmi, 1'b1});
        chk({cgc_run, clk_out_en, sys_clk_en, ctc_clk_en, wdt_clk_en}, 5'h1F);
        model.set_nmi(1'b1);
        chk(svc_start, 1'b1);
        model.set_int(1'b1);
        tick(1);
        $display("t_halt done mode=%0d", m);
    endtask

    // One I/O cycle with its automatic wait state
    task automatic t_io(input logic onchip);
        chk(dbus_oe, 1'b0);
        io_start = 1'b1;
        io_onchip = onchip;
        onchip_data = 8'h3C;
        tick(1);
        io_start = 1'b0;
        chk({dbus_oe, io_wait}, {onchip, 1'b0});
        tick(1);
        chk({io_wait, dbus}, {1'b0, onchip ? 8'h3C : 8'hC3});
        onchip_data = 8'hC3;
        tick(1);
        chk({io_wait, dbus}, {1'b1, 8'hC3});
        tick(1);
        chk({io_wait, dbus_oe}, {1'b0, onchip});
        tick(1);
        $display("t_io done onchip=%0d", onchip);
    endtask

    // Masked request wakes the clocks but is not accepted
    task automatic t_masked;
        int_enable = 1'b0;
        mode = MODE_LIGHT_SLEEP;
        halt_instr = 1'b1;
        tick(1);
        halt_instr = 1'b0;
        model.set_int(1'b0);
        tick(12);
        chk({int_ack, halt_n, sys_clk_en}, 3'h1);
        model.set_int(1'b1);
        tick(8);
        chk({halt_n, iff_set}, 2'h2);
        int_enable = 1'b1;
        $display("t_masked done");
    endtask

    // Pin reset: acceptance and stretching
    task automatic t_ext_reset(input logic stretch, input int len, input logic halt_first);
        int n;
        int i;
        if (halt_first) begin
            mode = MODE_STOP;
            halt_instr = 1'b1;
            tick(1);
            halt_instr = 1'b0;
        end
        reset_out_en = stretch;
        n = 0;
        fork
            model.pulse_reset(len);
        join_none
        for (i = 0; i < 60; i++) begin
            tick(1);
            if (bus_float === 1'b1) begin
                n++;
                chk({core_rst, halt_n, dbus_oe}, 3'h6);
            end
        end
        if (stretch)
            chk(n >= 16 && n < 30, 1'b1);
        else
            chk(n > 0, len >= 3);
        chk({halt_n, cgc_run, core_rst}, 3'h6);
        $display("t_ext_reset done stretch=%0d len=%0d", stretch, len);
    endtask

    // Cycle ceiling
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        reset_n_i = 1'b0;
        mode = MODE_RUN;
        reset_out_en = 1'b0;
        int_enable = 1'b1;
        halt_instr = 1'b0;
        io_start = 1'b0;
        io_onchip = 1'b0;
        onchip_data = 8'h00;
        tick(12);
        reset_n_i = 1'b1;
        t_reset_exit();
        t_halt(MODE_LIGHT_SLEEP, 5'h10, 1'b0);
        t_halt(MODE_TIMER_SLEEP, 5'h1A, 1'b0);
        t_halt(MODE_STOP, 5'h00, 1'b1);
        t_halt(MODE_RUN, 5'h1F, 1'b1);
        t_masked();
        t_io(1'b1);
        t_io(1'b0);
        t_ext_reset(1'b0, 2, 1'b0);
        t_ext_reset(1'b0, 3, 1'b1);
        t_ext_reset(1'b1, 2, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
